// *** common/pwr_seq_pkg.sv ***
/*
  Constants, types and register map for the domain power sequencer.
  Assumes one controller clock and an asynchronous active-high reset.
*/
// What this block does
// RULE_01: Command field is 4 bits; undefined command codes leave stored command unchanged.
// RULE_02: Manager domain has no command register; writes ignored, reads zero.
// RULE_03: Command register reads the last executed command.
// RULE_04: Clock-off waits for coherence off and interlocks, then gates clock.
// RULE_05: Clock-off to powered-down domain powers it up into ungated clock-off.
// RULE_06: Power-down waits for coherence off and interlocks, then powers down.
// RULE_07: Power-up command acts like the wake pin; other-core path only.
// RULE_08: Reset command in non-coherent mode resets, then reads back power-up.
// RULE_09: Command reset value derives from sampled cold-start policy pins.
// RULE_10: L2 auto-init waits delay after reset, one request per reset, gated.
// RULE_11: Wake pin power-up sets wake event flag and loads power-up code.
// RULE_12: Read-only four-bit field reports the sequencer state codes.
// RULE_13: Gating-present bits; when absent sequences run without physical gating.
// RULE_14: Probe event sets flag, powers up, resets, clock-off; no power-off meanwhile.
// RULE_15: Status bits show synchronized domain input pins.
// RULE_16: Cold-start policy: 0 down, 1 clock-off, 2 run, 3 reserved.
// RULE_17: Stand-alone IO bit makes manager low-power state clock-off.
// RULE_18: Clearing IO bit with wake low and processors down powers manager down.
// RULE_19: Manager power-down clears its control registers (code clears only the IO bit, not the L2 init enable); power-up resets it.
// RULE_20: Status command field mirrors latest command; power-up after reset or wake.
// RULE_21: Reserved bits read zero and ignore writes.
package pwr_seq_pkg;

  // ====
  // Register map
  localparam logic [15:0] OFF_MGR_STAT = 16'h9008;
  localparam logic [15:0] OFF_DBG_CMD = 16'h9100;
  localparam logic [15:0] OFF_DBG_STAT = 16'h9108;
  localparam logic [15:0] OFF_CORE_CMD = 16'hA000;
  localparam logic [15:0] OFF_CORE_STAT = 16'hA008;

  // ====
  // Status field positions
  localparam int B_L2INIT = 24;
  localparam int B_WAKEEV = 23;
  localparam int B_STATE_LO = 19;
  localparam int B_CLKGATE = 17;
  localparam int B_PWRGATE = 16;
  localparam int B_PROBE = 15;
  localparam int B_WAKE = 14;
  localparam int B_SUPPLY = 13;
  localparam int B_RAIL = 12;
  localparam int B_COH = 11;
  localparam int B_LOW_POWER_ACK_SYNC = 10;
  localparam int B_POLICY_LO = 8;
  localparam int B_HOLD = 7;
  localparam int B_IOTRF = 4;

  // ====
  // Commands
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_CLKOFF = 4'h1;
  localparam logic [3:0] CMD_PWRDN = 4'h2;
  localparam logic [3:0] CMD_POWER_ON_REQUEST = 4'h3;
  localparam logic [3:0] CMD_RESET = 4'h4;

  // ====
  // Sequencer state codes as reported
  localparam logic [3:0] SC_D0 = 4'h0;
  localparam logic [3:0] SC_U0 = 4'h1;
  localparam logic [3:0] SC_U1 = 4'h2;
  localparam logic [3:0] SC_U2 = 4'h3;
  localparam logic [3:0] SC_U3 = 4'h4;
  localparam logic [3:0] SC_U4 = 4'h5;
  localparam logic [3:0] SC_U5 = 4'h6;
  localparam logic [3:0] SC_U6 = 4'h7;
  localparam logic [3:0] SC_D1 = 4'h8;
  localparam logic [3:0] SC_D3 = 4'h9;
  localparam logic [3:0] SC_D2 = 4'hA;

  // Cold-start policy codes
  localparam logic [1:0] POL_DOWN = 2'h0;
  localparam logic [1:0] POL_CLKOFF = 2'h1;
  localparam logic [1:0] POL_RUN = 2'h2;

  // ====
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int UP_DELAY_NS = 40;
  localparam int UP_DELAY_CYC = (UP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CYC = 8;
  localparam int L2_WAIT_DEF = 64;

  // ====
  // Types
  typedef struct packed {
    logic wake;
    logic supplyGood;
    logic railStable;
    logic coherence;
    logic lowPowerAck;
    logic resetHold;
  } dom_pins_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// *** rtl/domain_power_sequencer.sv ***
/*
  Register front end and three domain sequencers (manager, debug, core).
  Assumes pins synchronous to clk_sys; a plain register port.
*/
module domain_power_sequencer #(
  parameter int L2_WAIT = pwr_seq_pkg::L2_WAIT_DEF,
  parameter bit L2_INIT_DEFAULT = 1'b1
) (
  input wire logic clk_sys, // Controller clock
  input wire logic rst, // Async reset, active high
  input wire pwr_seq_pkg::reg_req_t req, // Register request
  output logic [31:0] rdata, // Read data, cycle after read
  input wire pwr_seq_pkg::dom_pins_t mgrPins, // Manager domain pins
  input wire pwr_seq_pkg::dom_pins_t dbgPins, // Debug domain pins
  input wire pwr_seq_pkg::dom_pins_t corePins, // Core domain pins
  input wire logic [1:0] dbgColdPolicy, // Debug cold-start pins
  input wire logic [1:0] coreColdPolicy, // Core cold-start pins
  input wire logic probeAttach, // Probe connection pulse
  input wire logic bistOn, // BIST running
  input wire logic l2InitInhibitPin, // L2 init inhibit
  output logic l2InitReq, // L2 init request pulse
  output logic [2:0] domClkEnable, // Clock enables core,dbg,mgr
  output logic [2:0] domPwrEnable, // Power enables core,dbg,mgr
  output logic [2:0] domReset // Resets core,dbg,mgr
);
  import pwr_seq_pkg::*;

  // ====
  // Synchronizers for domain pins
  dom_pins_t mgrS1, mgrS2, dbgS1, dbgS2, coreS1, coreS2;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mgrS1 <= '0;
      mgrS2 <= '0;
      dbgS1 <= '0;
      dbgS2 <= '0;
      coreS1 <= '0;
      coreS2 <= '0;
    end else begin
      mgrS1 <= mgrPins;
      mgrS2 <= mgrS1; // [RULE_15]
      dbgS1 <= dbgPins;
      dbgS2 <= dbgS1;
      coreS1 <= corePins;
      coreS2 <= coreS1;
    end
  end

  // ====
  // Policy capture after reset release
  logic [1:0] dbgPol_reg, dbgPol_next, corePol_reg, corePol_next;
  logic started_reg, started_next;
  logic policyLoad;
  assign policyLoad = !started_reg;
  always_comb begin
    started_next = 1'b1;
    dbgPol_next = policyLoad ? dbgColdPolicy : dbgPol_reg; // [RULE_09]
    corePol_next = policyLoad ? coreColdPolicy : corePol_reg;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      started_reg <= 1'b0;
      dbgPol_reg <= 2'h0;
      corePol_reg <= 2'h0;
    end else begin
      started_reg <= started_next;
      dbgPol_reg <= dbgPol_next;
      corePol_reg <= corePol_next;
    end
  end

  // ====
  // Software control bits
  logic l2En_reg, l2En_next, io_reg, io_next;
  logic wrMgrStat, wrDbgStat, wrCoreStat, wrDbgCmd, wrCoreCmd;
  logic mgrDown;
  assign wrMgrStat = req.wr && (req.addr == OFF_MGR_STAT);
  assign wrDbgStat = req.wr && (req.addr == OFF_DBG_STAT);
  assign wrCoreStat = req.wr && (req.addr == OFF_CORE_STAT);
  assign wrDbgCmd = req.wr && (req.addr == OFF_DBG_CMD);
  assign wrCoreCmd = req.wr && (req.addr == OFF_CORE_CMD);

  always_comb begin
    l2En_next = l2En_reg;
    io_next = io_reg;
    if (wrMgrStat) begin
      l2En_next = req.wdata[B_L2INIT]; // [RULE_10]
      io_next = req.wdata[B_IOTRF]; // [RULE_17]
    end
    if (mgrDown) begin
      io_next = 1'b0; // [RULE_19]
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      l2En_reg <= L2_INIT_DEFAULT;
      io_reg <= 1'b0;
    end else begin
      l2En_reg <= l2En_next;
      io_reg <= io_next;
    end
  end

  // ====
  // L2 auto-init: one request per reset
  logic [15:0] l2Cnt_reg, l2Cnt_next;
  logic l2Done_reg, l2Done_next, l2Req_next;
  always_comb begin
    l2Cnt_next = l2Cnt_reg;
    l2Done_next = l2Done_reg;
    l2Req_next = 1'b0;
    if (l2Cnt_reg != 16'(L2_WAIT)) begin
      l2Cnt_next = l2Cnt_reg + 16'h0001;
    end else if (!l2Done_reg && l2En_reg && !bistOn && !l2InitInhibitPin) begin
      l2Req_next = 1'b1; // [RULE_10]
      l2Done_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      l2Cnt_reg <= 16'h0000;
      l2Done_reg <= 1'b0;
      l2InitReq <= 1'b0;
    end else begin
      l2Cnt_reg <= l2Cnt_next;
      l2Done_reg <= l2Done_next;
      l2InitReq <= l2Req_next;
    end
  end

  // ====
  // Sequencers
  logic [3:0] mgrState, dbgState, coreState, mgrCmd, dbgCmd, coreCmd;
  logic mgrWake, dbgWake, coreWake, dbgProbe, dbgDown, coreDown;

  domain_seq #(.IS_MGR(1'b1), .IS_DBG(1'b0)) u_mgr (
    .clk_sys(clk_sys), .rst(rst), .policy(POL_DOWN), .policyLoad(1'b0),
    .pins(mgrS2), .cmdWr(1'b0), .cmdData(4'h0), .probeEvent(1'b0),
    .probeClr(1'b0), .wakeClr(wrMgrStat && !req.wdata[B_WAKEEV]),
    .ioTraffic(io_reg), .othersDown(dbgDown && coreDown),
    .stateCode(mgrState), .lastCmd(mgrCmd), .wakeEvent(mgrWake), .probeSeen(),
    .clkEnable(domClkEnable[0]), .pwrEnable(domPwrEnable[0]),
    .domainReset(domReset[0]), .isDown(mgrDown)
  );

  domain_seq #(.IS_MGR(1'b0), .IS_DBG(1'b1)) u_dbg (
    .clk_sys(clk_sys), .rst(rst), .policy(dbgColdPolicy), .policyLoad(policyLoad),
    .pins(dbgS2), .cmdWr(wrDbgCmd), .cmdData(req.wdata[3:0]),
    .probeEvent(probeAttach), .probeClr(wrDbgStat && !req.wdata[B_PROBE]),
    .wakeClr(wrDbgStat && !req.wdata[B_WAKEEV]), .ioTraffic(1'b0),
    .othersDown(1'b0), .stateCode(dbgState), .lastCmd(dbgCmd),
    .wakeEvent(dbgWake), .probeSeen(dbgProbe), .clkEnable(domClkEnable[1]),
    .pwrEnable(domPwrEnable[1]), .domainReset(domReset[1]), .isDown(dbgDown)
  );

  domain_seq #(.IS_MGR(1'b0), .IS_DBG(1'b0)) u_core (
    .clk_sys(clk_sys), .rst(rst), .policy(coreColdPolicy), .policyLoad(policyLoad),
    .pins(coreS2), .cmdWr(wrCoreCmd), .cmdData(req.wdata[3:0]),
    .probeEvent(1'b0), .probeClr(1'b0),
    .wakeClr(wrCoreStat && !req.wdata[B_WAKEEV]), .ioTraffic(1'b0),
    .othersDown(1'b0), .stateCode(coreState), .lastCmd(coreCmd),
    .wakeEvent(coreWake), .probeSeen(), .clkEnable(domClkEnable[2]),
    .pwrEnable(domPwrEnable[2]), .domainReset(domReset[2]), .isDown(coreDown)
  );

  // ====
  // Read path
  function automatic logic [31:0] statWord(input logic l2, input logic wk,
      input logic [3:0] st, input logic pr, input dom_pins_t p,
      input logic [1:0] pol, input logic io, input logic [3:0] cmd);
    logic [31:0] w;
    w = 32'h0000_0000; // [RULE_21]
    w[B_L2INIT] = l2;
    w[B_WAKEEV] = wk;
    w[B_STATE_LO +: 4] = st; // [RULE_12]
    w[B_CLKGATE] = 1'b1; // [RULE_13]
    w[B_PWRGATE] = 1'b1;
    w[B_PROBE] = pr;
    w[B_WAKE] = p.wake; // [RULE_15]
    w[B_SUPPLY] = p.supplyGood;
    w[B_RAIL] = p.railStable;
    w[B_COH] = p.coherence;
    w[B_LOW_POWER_ACK_SYNC] = p.lowPowerAck;
    w[B_HOLD] = p.resetHold;
    w[B_POLICY_LO +: 2] = pol; // [RULE_16]
    w[B_IOTRF] = io;
    w[3:0] = cmd; // [RULE_20]
    return w;
  endfunction

  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (req.rd) begin
      if (req.addr == OFF_MGR_STAT) begin
        rdata_next = statWord(l2En_reg, mgrWake, mgrState, 1'b0, mgrS2, 2'h0, io_reg, mgrCmd);
      end else if (req.addr == OFF_DBG_CMD) begin
        rdata_next = {28'h000_0000, dbgCmd}; // [RULE_03]
      end else if (req.addr == OFF_DBG_STAT) begin
        rdata_next = statWord(1'b0, dbgWake, dbgState, dbgProbe, dbgS2, dbgPol_reg, 1'b0,
          dbgCmd);
      end else if (req.addr == OFF_CORE_CMD) begin
        rdata_next = {28'h000_0000, coreCmd};
      end else if (req.addr == OFF_CORE_STAT) begin
        rdata_next = statWord(1'b0, coreWake, coreState, 1'b0, coreS2, corePol_reg, 1'b0,
          coreCmd);
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule // domain_power_sequencer

// *** rtl/domain_seq.sv ***
/*
  One domain power sequencer: command holding, state walk and flags.
  Assumes pins already synchronized and command writes pre-decoded.
*/
// The strobed register port was chosen for this implementation.
module domain_seq #(
  parameter bit IS_MGR = 1'b0,
  parameter bit IS_DBG = 1'b0,
  parameter bit CLK_GATE_PRESENT = 1'b1,
  parameter bit PWR_GATE_PRESENT = 1'b1
) (
  input wire logic clk_sys, // Controller clock
  input wire logic rst, // Async reset
  input wire logic [1:0] policy, // Sampled cold-start policy
  input wire logic policyLoad, // Pulse after reset release
  input wire pwr_seq_pkg::dom_pins_t pins, // Synchronized domain pins
  input wire logic cmdWr, // Command write strobe
  input wire logic [3:0] cmdData, // Command write value
  input wire logic probeEvent, // Probe connection pulse
  input wire logic probeClr, // Software clears probe flag
  input wire logic wakeClr, // Software clears wake flag
  input wire logic ioTraffic, // Stand-alone IO traffic enable
  input wire logic othersDown, // All processor domains down
  output logic [3:0] stateCode, // Sequencer state code
  output logic [3:0] lastCmd, // Last executed command
  output logic wakeEvent, // Wake pin event flag
  output logic probeSeen, // Probe flag
  output logic clkEnable, // Domain clock enable
  output logic pwrEnable, // Domain power switch enable
  output logic domainReset, // Domain reset
  output logic isDown // Domain powered down
);
  import pwr_seq_pkg::*;

  // ====
  // State machine
  typedef enum logic [5:0] {
    S_DOWN = 6'b000001,
    S_RAMP = 6'b000010,
    S_GATED = 6'b000100,
    S_RESET = 6'b001000,
    S_RUN = 6'b010000,
    S_DRAIN = 6'b100000
  } st_t;

  st_t state_reg, state_next;
  logic [3:0] pend_reg, pend_next;
  logic [3:0] last_reg, last_next;
  logic [3:0] target_reg, target_next;
  logic [7:0] cnt_reg, cnt_next;
  logic wake_reg, wake_next;
  logic probe_reg, probe_next;
  logic wakePrev_reg, wakePrev_next;
  logic ioPrev_reg, ioPrev_next;
  logic barrierClear;
  logic wakeRise;

  assign barrierClear = !pins.coherence && pins.lowPowerAck && !pins.resetHold;
  assign wakeRise = pins.wake && !wakePrev_reg;

  always_comb begin
    state_next = state_reg;
    pend_next = pend_reg;
    last_next = last_reg;
    target_next = target_reg;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : cnt_reg;
    wake_next = wake_reg;
    probe_next = probe_reg;
    wakePrev_next = pins.wake;
    ioPrev_next = ioTraffic;
    if (policyLoad) begin
      // Cold-start policy picks the starting command
      case (policy) // [RULE_09] [RULE_16]
        POL_CLKOFF: pend_next = CMD_CLKOFF;
        POL_RUN: pend_next = CMD_POWER_ON_REQUEST;
        default: pend_next = CMD_NONE;
      endcase
    end else if (cmdWr && !IS_MGR) begin // [RULE_02]
      if (cmdData >= CMD_CLKOFF && cmdData <= CMD_RESET) begin // [RULE_01]
        pend_next = cmdData;
      end
    end
    if (wakeRise && state_reg == S_DOWN) begin
      pend_next = CMD_POWER_ON_REQUEST; // [RULE_07]
      wake_next = 1'b1; // [RULE_11]
      last_next = CMD_POWER_ON_REQUEST; // [RULE_20]
    end else if (wakeClr) begin
      wake_next = 1'b0;
    end
    if (probeEvent && IS_DBG) begin
      probe_next = 1'b1; // [RULE_14]
      pend_next = CMD_RESET;
      target_next = CMD_CLKOFF;
    end else if (probeClr) begin
      probe_next = 1'b0;
    end
    // Manager: IO bit dropped while idle powers the manager down
    if (IS_MGR && ioPrev_reg && !ioTraffic && !pins.wake && othersDown) begin // [RULE_18]
      pend_next = CMD_PWRDN;
    end
    case (state_reg)
      S_DOWN: begin
        if (pend_reg == CMD_CLKOFF || pend_reg == CMD_POWER_ON_REQUEST || pend_reg == CMD_RESET) begin
          target_next = pend_reg; // [RULE_05]
          last_next = pend_reg;
          pend_next = CMD_NONE;
          cnt_next = 8'(UP_DELAY_CYC);
          state_next = S_RAMP;
        end
      end
      S_RAMP: begin
        if (cnt_reg == 8'h00 && pins.supplyGood && pins.railStable) begin
          if (target_reg == CMD_CLKOFF) begin
            state_next = S_GATED; // [RULE_05]
          end else begin
            cnt_next = 8'(RST_CYC);
            state_next = S_RESET; // [RULE_19]
          end
        end
      end
      S_GATED: begin
        if (pend_reg == CMD_POWER_ON_REQUEST || pend_reg == CMD_RESET) begin
          last_next = pend_reg;
          pend_next = CMD_NONE;
          cnt_next = 8'(RST_CYC);
          state_next = S_RESET;
        end else if (pend_reg == CMD_PWRDN && barrierClear && !probe_reg && !ioTraffic) begin
          last_next = CMD_PWRDN; // [RULE_06] [RULE_14] [RULE_17]
          pend_next = CMD_NONE;
          state_next = S_DOWN;
        end else if (pend_reg == CMD_CLKOFF) begin
          pend_next = CMD_NONE;
        end
      end
      S_RESET: begin
        if (cnt_reg == 8'h00) begin
          if (probe_reg && target_reg != CMD_POWER_ON_REQUEST) begin
            last_next = CMD_CLKOFF; // [RULE_14]
            state_next = S_GATED;
          end else begin
            last_next = CMD_POWER_ON_REQUEST; // [RULE_08] [RULE_20]
            state_next = S_RUN;
          end
          target_next = CMD_POWER_ON_REQUEST;
        end
      end
      S_RUN: begin
        if (pend_reg == CMD_RESET && !pins.coherence) begin
          last_next = CMD_RESET; // [RULE_08]
          pend_next = CMD_NONE;
          cnt_next = 8'(RST_CYC);
          state_next = S_RESET;
        end else if ((pend_reg == CMD_CLKOFF || pend_reg == CMD_PWRDN) && barrierClear) begin
          target_next = pend_reg; // [RULE_04] [RULE_06]
          last_next = pend_reg; // [RULE_03]
          pend_next = CMD_NONE;
          state_next = S_DRAIN;
        end else if (pend_reg == CMD_POWER_ON_REQUEST) begin
          pend_next = CMD_NONE;
        end
      end
      S_DRAIN: begin
        // Power-off blocked while probe seen or IO traffic keeps manager alive
        if (target_reg == CMD_PWRDN && !probe_reg && !(IS_MGR && ioTraffic)) begin
          state_next = S_DOWN; // [RULE_14] [RULE_17] [RULE_19]
        end else begin
          state_next = S_GATED; // [RULE_04]
          target_next = CMD_NONE;
        end
      end
      default: state_next = S_DOWN;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= S_DOWN;
      pend_reg <= 4'h0;
      last_reg <= 4'h0;
      target_reg <= 4'h0;
      cnt_reg <= 8'h00;
      wake_reg <= 1'b0;
      probe_reg <= 1'b0;
      wakePrev_reg <= 1'b0;
      ioPrev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      last_reg <= last_next;
      target_reg <= target_next;
      cnt_reg <= cnt_next;
      wake_reg <= wake_next;
      probe_reg <= probe_next;
      wakePrev_reg <= wakePrev_next;
      ioPrev_reg <= ioPrev_next;
    end
  end

  // ====
  // Outputs
  always_comb begin
    case (state_reg) // [RULE_12]
      S_RAMP: stateCode = SC_U1;
      S_GATED: stateCode = (target_reg == CMD_CLKOFF && last_reg != CMD_POWER_ON_REQUEST) ? SC_U2 : SC_D2;
      S_RESET: stateCode = SC_U3;
      S_RUN: stateCode = pins.coherence ? SC_U6 : SC_U5;
      S_DRAIN: stateCode = SC_D3;
      default: stateCode = SC_D0;
    endcase
  end

  assign lastCmd = last_reg;
  assign wakeEvent = wake_reg;
  assign probeSeen = probe_reg;
  assign isDown = (state_reg == S_DOWN);
  assign domainReset = (state_reg != S_RUN) && (state_reg != S_GATED);
  // Without the physical gates the switches stay on
  assign clkEnable = !CLK_GATE_PRESENT || (state_reg == S_RUN) || (state_reg == S_RESET); // [RULE_13]
  assign pwrEnable = !PWR_GATE_PRESENT || (state_reg != S_DOWN); // [RULE_13]

endmodule // domain_seq

// *** tb/pwr_seq_props.sv ***
/* Checker on the sequencer top ports.
   Assumes it is bound into the top by name. */
module pwr_seq_chk
  import pwr_seq_pkg::*;
#(
  parameter int L2_WAIT = 64
) (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire pwr_seq_pkg::reg_req_t req, // Request
  input wire logic [31:0] rdata, // Read data
  input wire pwr_seq_pkg::dom_pins_t corePins, // Core pins
  input wire logic bistOn, // BIST
  input wire logic l2InitInhibitPin, // Inhibit
  input wire logic l2InitReq, // L2 pulse
  input wire logic [2:0] domClkEnable, // Clocks
  input wire logic [2:0] domPwrEnable // Power
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] cyc_reg;
  logic l2Done_reg, rdStat, rdCore;
  assign rdCore = req.rd && req.addr == OFF_CORE_STAT;
  assign rdStat = rdCore || (req.rd && req.addr == OFF_DBG_STAT);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyc_reg <= '0;
      l2Done_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
      l2Done_reg <= l2Done_reg | l2InitReq;
    end
  end
  property p_mgr_cmd;
    req.rd && req.addr == 16'h9000 |=> rdata == 32'h0000_0000;
  endproperty
  a_mgr_cmd: assert property (p_mgr_cmd) else $error("manager command nonzero");
  property p_cmd_rsvd;
    req.rd && (req.addr == OFF_CORE_CMD || req.addr == OFF_DBG_CMD) |=> rdata[31:4] == 28'h0;
  endproperty
  a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("command upper bits set");
  property p_stat_rsvd;
    rdStat |=> rdata[31:25] == 7'h0 && !rdata[18] && rdata[6:5] == 2'h0;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set");
  property p_mgr_only;
    rdStat |=> !rdata[24] && !rdata[4];
  endproperty
  a_mgr_only: assert property (p_mgr_only) else $error("manager bit set");
  property p_pin_sync;
    $stable(corePins) [*6] ##0 rdCore ##1 $stable(corePins)
      |-> rdata[14:10] == corePins[5:1] && rdata[7] == corePins[0];
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin copy wrong");
  property p_clk_pwr;
    domClkEnable[2] |-> domPwrEnable[2];
  endproperty
  a_clk_pwr: assert property (p_clk_pwr) else $error("clock without power");
  property p_coh_hold;
    corePins.coherence [*6] |-> !$fell(domClkEnable[2]);
  endproperty
  a_coh_hold: assert property (p_coh_hold) else $error("clock off while coherent");
  property p_l2_pulse;
    l2InitReq |=> !l2InitReq;
  endproperty
  a_l2_pulse: assert property (p_l2_pulse) else $error("L2 pulse too long");
  property p_l2_once;
    l2InitReq |-> !l2Done_reg && cyc_reg >= L2_WAIT - 1;
  endproperty
  a_l2_once: assert property (p_l2_once) else $error("L2 request early or twice");
  property p_l2_gate;
    (bistOn || l2InitInhibitPin) [*3] |-> !l2InitReq;
  endproperty
  a_l2_gate: assert property (p_l2_gate) else $error("L2 request while inhibited");
  c_l2: cover property (l2InitReq);
  c_clkoff: cover property ($fell(domClkEnable[2]));
  c_dbg_up: cover property ($rose(domPwrEnable[1]));
endmodule // pwr_seq_chk

bind domain_power_sequencer pwr_seq_chk #(.L2_WAIT(L2_WAIT)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .corePins(corePins),
  .bistOn(bistOn), .l2InitInhibitPin(l2InitInhibitPin), .l2InitReq(l2InitReq),
  .domClkEnable(domClkEnable), .domPwrEnable(domPwrEnable));

// *** tb/rail_model.sv ***
/* Rail model: supply-good and rail-settled per domain.
   Assumes power enables from the sequencer and one clock. */
module rail_model #(
  parameter int LAG = 3
) (
  input wire logic clk_sys, // Clock
  input wire logic [2:0] pwrEn, // Switch enables
  output logic [2:0] supplyOk, // Supply good
  output logic [2:0] railOk // Rail settled
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] dly [LAG];
  always @(posedge clk_sys) begin
    dly[0] <= pwrEn;
    for (int i = 1; i < LAG; i++) dly[i] <= dly[i-1];
  end
  // Rails drop at once when a switch opens
  assign supplyOk = pwrEn & dly[0];
  assign railOk = pwrEn & dly[LAG-1];
endmodule // rail_model

// *** tb/testbench.sv ***
/* Self-checking bench for the domain power sequencer.
   Assumes package, design, checker and rail model compiled first. */
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
`define WAIT(c) begin \
  for (n = 0; (c) !== 1'b1 && n < 500; n++) @(posedge clk_sys); \
  if (n >= 500) begin \
    bad_count++; \
    print_verdict(); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pwr_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [31:0] rdata;
  logic [31:0] r, got, want;
  logic [3:0] v;
  dom_pins_t mgrPins, dbgPins, corePins;
  logic [1:0] dbgPol = 2'h0;
  logic [1:0] corePol = 2'h2;
  logic probe = 1'b0, bistOn = 1'b0, inhibit = 1'b0, low_power_ack_sync = 1'b1, hold = 1'b0;
  logic mWake = 1'b0, dWake = 1'b0, cWake = 1'b0, cCoh = 1'b0, rdLast = 1'b0;
  logic l2InitReq;
  logic [2:0] clkEn, pwrEn, domRst, supOk, railOk;
  int bad_count = 0, tests_run = 0, l2Seen = 0, seed = 43, n;
  logic [31:0] expQ[$], mskQ[$];
  always #2 clk_sys = ~clk_sys;
  assign mgrPins = {mWake, supOk[0], railOk[0], 1'b0, low_power_ack_sync, hold};
  assign dbgPins = {dWake, supOk[1], railOk[1], 1'b0, low_power_ack_sync, hold};
  assign corePins = {cWake, supOk[2], railOk[2], cCoh, low_power_ack_sync, hold};
  rail_model #(.LAG(3)) u_rail (.clk_sys(clk_sys), .pwrEn(pwrEn), .supplyOk(supOk),
    .railOk(railOk));
  domain_power_sequencer #(.L2_WAIT(8), .L2_INIT_DEFAULT(1'b1)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .mgrPins(mgrPins),
    .dbgPins(dbgPins), .corePins(corePins), .dbgColdPolicy(dbgPol),
    .coreColdPolicy(corePol), .probeAttach(probe), .bistOn(bistOn),
    .l2InitInhibitPin(inhibit), .l2InitReq(l2InitReq), .domClkEnable(clkEn),
    .domPwrEnable(pwrEn), .domReset(domRst));
  // ====
  // Bus tasks and result monitor
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    if (rdLast) begin
      got = rdata & mskQ.pop_front();
      want = expQ.pop_front();
      `CHK(got, want)
    end
    rdLast = req.rd;
  end
  always @(posedge clk_sys) if (l2InitReq === 1'b1) l2Seen++;
  // ====
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    `WAIT(pwrEn[2] && clkEn[2] && !domRst[2])
    repeat (6) @(posedge clk_sys);
    rd(OFF_CORE_STAT, 32'h007B_0300, 32'h0033_0200);
    rd(OFF_DBG_STAT, 32'h007B_0300, 32'h0003_0000);
    rd(OFF_MGR_STAT, 32'h0100_0010, 32'h0100_0000);
    wr(16'h9000, 32'h0000_0003);
    rd(16'h9000, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(16'h1234, 32'hFFFF_FFFF, 32'h0000_0000);
    cCoh <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(OFF_CORE_CMD, 32'h0000_0001);
    repeat (20) @(posedge clk_sys);
    `CHK(clkEn[2], 1'b1)
    cCoh <= 1'b0;
    `WAIT(!clkEn[2])
    rd(OFF_CORE_CMD, 32'hFFFF_FFFF, 32'h0000_0001);
    rd(OFF_CORE_STAT, 32'h0078_000F, 32'h0050_0001);
    r = $random(seed);
    v = r[3:0];
    if (v >= 4'h1 && v <= 4'h4) v = v + 4'h4;
    wr(OFF_CORE_CMD, {r[31:4], v});
    rd(OFF_CORE_CMD, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(OFF_CORE_CMD, 32'h0000_0004);
    `WAIT(domRst[2])
    `WAIT(!domRst[2] && clkEn[2])
    repeat (6) @(posedge clk_sys);
    rd(OFF_CORE_CMD, 32'hFFFF_FFFF, 32'h0000_0003);
    rd(OFF_CORE_STAT, 32'h0078_000F, 32'h0030_0003);
    wr(OFF_CORE_CMD, 32'h0000_0002);
    `WAIT(!pwrEn[2])
    rd(OFF_CORE_STAT, 32'h0078_000F, 32'h0000_0002);
    wr(OFF_CORE_CMD, 32'h0000_0001);
    repeat (40) @(posedge clk_sys);
    rd(OFF_CORE_STAT, 32'h0078_000F, 32'h0018_0001);
    wr(OFF_CORE_CMD, 32'h0000_0003);
    `WAIT(clkEn[2] && !domRst[2])
    rd(OFF_CORE_CMD, 32'hFFFF_FFFF, 32'h0000_0003);
    dWake <= 1'b1;
    `WAIT(pwrEn[1])
    dWake <= 1'b0;
    `WAIT(clkEn[1] && !domRst[1])
    rd(OFF_DBG_STAT, 32'h0080_000F, 32'h0080_0003);
    wr(OFF_DBG_STAT, 32'h0000_0000);
    rd(OFF_DBG_STAT, 32'h0080_0000, 32'h0000_0000);
    probe <= 1'b1;
    @(posedge clk_sys);
    probe <= 1'b0;
    `WAIT(domRst[1])
    `WAIT(!clkEn[1] && !domRst[1])
    rd(OFF_DBG_STAT, 32'h0000_8000, 32'h0000_8000);
    wr(OFF_DBG_CMD, 32'h0000_0002);
    repeat (40) @(posedge clk_sys);
    `CHK(pwrEn[1], 1'b1)
    `CHK(l2Seen, 1)
    mWake <= 1'b1;
    `WAIT(clkEn[0])
    wr(OFF_MGR_STAT, 32'h0100_0010);
    rd(OFF_MGR_STAT, 32'h0100_0010, 32'h0100_0010);
    inhibit <= 1'b1;
    corePol <= 2'h1;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (60) @(posedge clk_sys);
    rd(OFF_CORE_STAT, 32'h0078_0300, 32'h0018_0100);
    `CHK(l2Seen, 1)
    print_verdict();
  end
endmodule // testbench
